// ===== design/taeacc_top.sv
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module taeacc_top
  import taeacc_pkg::*;
#(
  parameter int RMS_W = 16,
  parameter int PROD_SHIFT = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [RMS_W-1:0] phase_a_volt_rms,
  input wire logic [RMS_W-1:0] phase_b_volt_rms,
  input wire logic [RMS_W-1:0] phase_c_volt_rms,
  input wire logic [RMS_W-1:0] phase_a_curr_rms,
  input wire logic [RMS_W-1:0] phase_b_curr_rms,
  input wire logic [RMS_W-1:0] phase_c_curr_rms,
  output logic half_full_pulse
);
  localparam int W = 2 * RMS_W + 2;

  // refuse widths the datapath cannot hold
  if (RMS_W < 8 || RMS_W > 24) begin : g_bad_rms
    $error("rms width must lie between 8 and 24");
  end
  if (PROD_SHIFT < 0 || PROD_SHIFT >= 2 * RMS_W) begin : g_bad_shift
    $error("product shift out of range");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [RMS_W-1:0] va_q;
  logic [RMS_W-1:0] vb_q;
  logic [RMS_W-1:0] vc_q;
  logic [RMS_W-1:0] ia_q;
  logic [RMS_W-1:0] ib_q;
  logic [RMS_W-1:0] ic_q;
  logic [7:0] mode_q;
  logic [DIV_W-1:0] div_q;
  logic [GAIN_W-1:0] vag_q [3];
  logic [GAIN_W-1:0] apg_q [3];
  logic signed [ACC_W-1:0] total_q;
  logic signed [ACC_W-1:0] acc_q;
  logic signed [ACC_W-1:0] acc_d;
  logic [EN_W-1:0] energy_q;
  logic hf_q;
  logic ie_q;
  logic flag_q;
  logic [DATA_W-1:0] rdata_q;

  wire logic tick;
  wire logic [1:0] sel_raw;
  wire logic [1:0] sel_eff;
  wire logic [2:0] term_en;
  wire logic [RMS_W:0] av_sum;
  wire logic [RMS_W-1:0] av_half;
  wire logic [RMS_W-1:0] mid_v;
  wire logic [RMS_W-1:0] tv [3];
  wire logic [RMS_W-1:0] ti [3];
  wire logic signed [W-1:0] term_w [3];
  wire logic signed [ACC_W-1:0] total_d;
  wire logic [DIV_W-1:0] div_eff;
  wire logic signed [ACC_W-1:0] quot;
  wire logic hf_now;
  wire logic hf_evt;

  // sample strobe: one cycle in every twelve
  assign tick = (cnt_q == CNT_W'(SAMPLE_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // rms magnitudes are caught once per sample period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      va_q <= '0;
      vb_q <= '0;
      vc_q <= '0;
      ia_q <= '0;
      ib_q <= '0;
      ic_q <= '0;
    end else if (tick) begin
      va_q <= phase_a_volt_rms;
      vb_q <= phase_b_volt_rms;
      vc_q <= phase_c_volt_rms;
      ia_q <= phase_a_curr_rms;
      ib_q <= phase_b_curr_rms;
      ic_q <= phase_c_curr_rms;
    end
  end

  // phase combination decode; the undefined code falls back to mode 0
  assign sel_raw = mode_q[MODE_SEL_HI:MODE_SEL_LO];
  assign sel_eff = (sel_raw == COMB_UNDEF) ? COMB_ABC : sel_raw;
  assign term_en = mode_q[MODE_EN_HI:MODE_EN_LO];
  assign av_sum = {1'b0, va_q} + {1'b0, vc_q};
  assign av_half = av_sum[RMS_W:1];
  assign mid_v = (sel_eff == COMB_AVG) ? av_half :
                 (sel_eff == COMB_AIB) ? va_q : vb_q;

  // first and last term voltages never change with the mode
  assign tv[0] = va_q;
  assign tv[1] = mid_v;
  assign tv[2] = vc_q;
  assign ti[0] = ia_q;
  assign ti[1] = ib_q;
  assign ti[2] = ic_q;

  // one gain-corrected, gated term per phase
  for (genvar g = 0; g < 3; g++) begin : g_term
    taeacc_term_if #(.RMS_W(RMS_W)) tif ();
    assign tif.v = tv[g];
    assign tif.i = ti[g];
    assign tif.va_gain = vag_q[g];
    assign tif.ap_gain = apg_q[g];
    assign tif.en = term_en[g];
    assign term_w[g] = tif.term;
    taeacc_term #(
      .RMS_W(RMS_W),
      .PROD_SHIFT(PROD_SHIFT)
    ) u_term (
      .tif(tif.calc)
    );
  end

  // each phase adds its own gated term to the sum
  assign total_d = ACC_W'(term_w[0]) + ACC_W'(term_w[1])
                 + ACC_W'(term_w[2]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      total_q <= '0;
    end else if (tick) begin
      total_q <= total_d;
    end
  end

  // apb decode; the slave answers with no wait state
  wire logic acc_ph;
  wire logic wr_en;
  wire logic rd_setup;
  wire logic hit_mode;
  wire logic hit_div;
  wire logic hit_en;
  wire logic hit_rc;
  wire logic hit_ctrl;
  wire logic [2:0] hit_vag;
  wire logic [2:0] hit_apg;
  wire logic hit_any;
  wire logic rc_clear;
  wire logic [DATA_W-1:0] rd_mux;

  assign acc_ph = psel & penable;
  assign wr_en = acc_ph & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit_mode = (paddr == OFF_MODE);
  assign hit_div = (paddr == OFF_DIV);
  assign hit_en = (paddr == OFF_ENERGY);
  assign hit_rc = (paddr == OFF_ENERGY_RC);
  assign hit_ctrl = (paddr == OFF_CTRL);
  for (genvar g = 0; g < 3; g++) begin : g_hit
    assign hit_vag[g] = (paddr == OFF_VAG[g]);
    assign hit_apg[g] = (paddr == OFF_APG[g]);
  end
  assign hit_any = hit_mode | hit_div | hit_en | hit_rc | hit_ctrl
                 | (|hit_vag) | (|hit_apg);
  assign rc_clear = acc_ph & ~pwrite & hit_rc;
  assign pready = 1'b1;
  assign pslverr = acc_ph & ~hit_any;
  assign prdata = rdata_q;

  // read selection, reserved bits read as zero
  assign rd_mux =
    hit_mode ? DATA_W'(mode_q) :
    hit_div ? DATA_W'(div_q) :
    (hit_en | hit_rc) ? DATA_W'(energy_q) :
    hit_vag[0] ? DATA_W'(vag_q[0]) :
    hit_vag[1] ? DATA_W'(vag_q[1]) :
    hit_vag[2] ? DATA_W'(vag_q[2]) :
    hit_apg[0] ? DATA_W'(apg_q[0]) :
    hit_apg[1] ? DATA_W'(apg_q[1]) :
    hit_apg[2] ? DATA_W'(apg_q[2]) :
    hit_ctrl ? DATA_W'({flag_q, ie_q}) : '0;

  // read data is latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else if (rd_setup) begin
      rdata_q <= rd_mux;
    end
  end

  // mode and divider registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RST;
      div_q <= DIV_RST;
    end else if (wr_en) begin
      if (hit_mode) begin
        mode_q <= pwdata[7:0];
      end
      if (hit_div) begin
        div_q <= pwdata[DIV_W-1:0];
      end
    end
  end

  // per-phase gain registers
  for (genvar g = 0; g < 3; g++) begin : g_gain
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        vag_q[g] <= GAIN_RST;
        apg_q[g] <= GAIN_RST;
      end else if (wr_en) begin
        if (hit_vag[g]) begin
          vag_q[g] <= pwdata[GAIN_W-1:0];
        end
        if (hit_apg[g]) begin
          apg_q[g] <= pwdata[GAIN_W-1:0];
        end
      end
    end
  end

  // signed accumulation; a sample in the clearing cycle is kept
  always_comb begin
    acc_d = acc_q;
    if (rc_clear) begin
      acc_d = tick ? total_q : '0;
    end else if (tick) begin
      acc_d = acc_q + total_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  // divider view: zero divides by one, larger values slow the count
  assign div_eff = (div_q == '0) ? DIV_W'(1) : div_q;
  assign quot = acc_q / $signed({1'b0, div_eff});

  // upper bits wrap naturally past full scale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      energy_q <= '0;
    end else begin
      energy_q <= quot[ACC_W-1 -: EN_W];
    end
  end

  // half full: top two bits differ, positive or negative
  assign hf_now = energy_q[EN_W-1] ^ energy_q[EN_W-2];
  assign hf_evt = hf_now & ~hf_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_q <= 1'b0;
      half_full_pulse <= 1'b0;
    end else begin
      hf_q <= hf_now;
      half_full_pulse <= hf_evt & ie_q;
    end
  end

  // control: enable bit, sticky flag cleared by writing one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      if (wr_en && hit_ctrl) begin
        ie_q <= pwdata[CTRL_IE_BIT];
      end
      if (hf_evt) begin
        flag_q <= 1'b1;
      end else if (wr_en && hit_ctrl && pwdata[CTRL_FLAG_BIT]) begin
        flag_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // helper: cycles since the last strobe, kept apart from the divider
  logic [CNT_W-1:0] gap_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= '0;
    end else if (tick) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_q + 1'b1;
    end
  end

  sequence s_cleared;
    acc_q == '0 ##1 energy_q == '0;
  endsequence

  AST_TICK_PERIOD: assert property (
    tick == (gap_q == CNT_W'(SAMPLE_CYC - 1)))
    else $error("sample strobe period is not twelve cycles");

  AST_ACC_ADD: assert property (
    tick && !rc_clear |=> acc_q == $past(acc_q) + $past(total_q))
    else $error("accumulator missed a sample addition");

  AST_ACC_HOLD: assert property (
    !tick && !rc_clear |=> acc_q == $past(acc_q))
    else $error("accumulator moved outside a sample");

  AST_RC_CLEAR: assert property (rc_clear && !tick |=> s_cleared)
    else $error("read-clear did not zero the energy");

  AST_MODE_UNDEF: assert property (
    sel_raw == COMB_UNDEF |-> mid_v == vb_q)
    else $error("undefined mode not treated as mode 0");

  AST_MID_TERM: assert property (
    sel_raw == COMB_AIB |-> mid_v == va_q && tv[2] == vc_q)
    else $error("middle term voltage wrong in mode 2");

  AST_TERM_OFF: assert property (
    !mode_q[MODE_EN_LO + 1] |-> term_w[1] == '0)
    else $error("disabled term still contributes");

  AST_DIV_ZERO: assert property (
    div_q == '0 |=> energy_q == $past(acc_q[ACC_W-1 -: EN_W]))
    else $error("zero divider does not divide by one");

  AST_HALF_PULSE: assert property (
    half_full_pulse |-> $past(ie_q) && hf_q && !$past(hf_q))
    else $error("half-full pulse without a fresh crossing");

  AST_FLAG_SET: assert property (hf_evt |=> flag_q)
    else $error("half-full flag not set");

  AST_RDATA: assert property (
    rd_setup && hit_en |=> prdata == DATA_W'($past(energy_q)))
    else $error("energy read returned wrong value");
endmodule

`default_nettype wire

// ===== design/taeacc_pkg.sv
`default_nettype none

package taeacc_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int ACC_W = 49;
  localparam int EN_W = 24;
  localparam int GAIN_W = 12;
  localparam int GAIN_FRAC = 12;
  localparam int DIV_W = 8;
  localparam int CLK_NS = 100;
  localparam int SAMPLE_NS = 1200;
  localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
  localparam int CNT_W = $clog2(SAMPLE_CYC);
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DIV = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ENERGY = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ENERGY_RC = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_VAG [3] = '{8'h10, 8'h14, 8'h18};
  localparam logic [ADDR_W-1:0] OFF_APG [3] = '{8'h1c, 8'h20, 8'h24};
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h28;
  // field positions and reset values
  localparam int MODE_SEL_HI = 7;
  localparam int MODE_SEL_LO = 6;
  localparam int MODE_EN_HI = 2;
  localparam int MODE_EN_LO = 0;
  localparam int CTRL_IE_BIT = 0;
  localparam int CTRL_FLAG_BIT = 1;
  localparam logic [7:0] MODE_RST = 8'h07;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
  localparam logic [GAIN_W-1:0] GAIN_RST = 12'h000;
  // phase combination codes
  localparam logic [1:0] COMB_ABC = 2'h0;
  localparam logic [1:0] COMB_AVG = 2'h1;
  localparam logic [1:0] COMB_AIB = 2'h2;
  localparam logic [1:0] COMB_UNDEF = 2'h3;
endpackage

`default_nettype wire

// ===== design/taeacc_term_if.sv
`timescale 1ns/10ps
`default_nettype none

interface taeacc_term_if
  import taeacc_pkg::*;
#(
  parameter int RMS_W = 16
);
  logic [RMS_W-1:0] v;
  logic [RMS_W-1:0] i;
  logic [GAIN_W-1:0] va_gain;
  logic [GAIN_W-1:0] ap_gain;
  logic en;
  logic signed [2*RMS_W+1:0] term;
  modport calc (input v, input i, input va_gain, input ap_gain,
    input en, output term);
  modport user (output v, output i, output va_gain, output ap_gain,
    output en, input term);
endinterface

`default_nettype wire

// ===== design/taeacc_term.sv
`timescale 1ns/10ps
`default_nettype none

module taeacc_term
  import taeacc_pkg::*;
#(
  parameter int RMS_W = 16,
  parameter int PROD_SHIFT = 12
) (
  taeacc_term_if.calc tif
);
  localparam int W = 2 * RMS_W + 2;

  // scale by (1 + g / 2^12); 7ffh gives the largest, 800h the least
  function automatic logic signed [W-1:0] gain_scale(
    input logic signed [W-1:0] x,
    input logic signed [GAIN_W-1:0] g);
    logic signed [W+GAIN_W-1:0] p;
    p = x * g;
    gain_scale = x + W'(p >>> GAIN_FRAC);
  endfunction

  wire logic [2*RMS_W-1:0] prod;
  wire logic signed [W-1:0] base;
  wire logic signed [W-1:0] ap_adj;
  wire logic signed [W-1:0] va_adj;

  // rms product, then active and apparent gain corrections
  assign prod = tif.v * tif.i;
  assign base = $signed({2'b00, prod >> PROD_SHIFT});
  assign ap_adj = gain_scale(base, $signed(tif.ap_gain));
  assign va_adj = gain_scale(ap_adj, $signed(tif.va_gain));
  assign tif.term = tif.en ? va_adj : '0;
endmodule

`default_nettype wire

// ===== sim/taeacc_rms_src.sv
`timescale 1ns/10ps
`default_nettype none

// rms stage stand-in: magnitudes 0..5 are va, vb, vc, ia, ib, ic
module taeacc_rms_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0][23:0] req,
  output logic [5:0][23:0] rms
);
  logic [3:0] cnt_q;

  // new magnitudes appear only once per sample period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      rms <= '0;
    end else begin
      cnt_q <= (cnt_q == 4'hb) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'hb) begin
        rms <= req;
      end
    end
  end
endmodule

`default_nettype wire

// ===== sim/taeacc_bench.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(A, B) begin total_checks++; if ((A) !== (B)) begin \
  miscompares++; $display("MISMATCH t=%0t got %h exp %h", $time, A, B); \
  end end

module taeacc_bench
  import taeacc_pkg::*;
;
  typedef struct {logic [31:0] v; logic e; int d; int kl; int kh;}
    taeacc_note_t;
  localparam int U = 'h80000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic half_full_pulse;
  logic [5:0][23:0] req = '0;
  logic [5:0][23:0] rms;
  int miscompares = 0;
  int total_checks = 0;
  int pulses = 0;
  int seed = 32'hb492;
  taeacc_note_t q[$];
  // mode, va, vb, vc, ia, ib, ic, vag, apg, div, energy step per tick
  int tbl [9][11] = '{
    '{'hc2, -1, U, -1, -1, U, -1, 0, 0, 0, 8192},
    '{'h82, U, -1, -1, -1, U, -1, 0, 0, 0, 8192},
    '{'h02, -1, 'h40000, -1, -1, U, -1, 0, 0, 0, 4096},
    '{'h42, U, -1, 'h180000, -1, U, -1, 0, 0, 0, 16384},
    '{'h05, U, -1, U, U, -1, 'h40000, 0, 0, 0, 12288},
    '{'h01, U, -1, -1, U, -1, -1, 'h400, 0, 0, 10240},
    '{'h01, U, -1, -1, U, -1, -1, 0, 'hc00, 0, 6144},
    '{'h01, U, -1, -1, U, -1, -1, 0, 0, 2, 4096},
    '{'h01, U, -1, -1, U, -1, -1, 0, 0, 0, 8192}};

  taeacc_rms_src rms_src (.pclk(pclk), .presetn(presetn), .req(req),
    .rms(rms));

  taeacc_top #(.RMS_W(24), .PROD_SHIFT(0)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phase_a_volt_rms(rms[0]),
    .phase_b_volt_rms(rms[1]), .phase_c_volt_rms(rms[2]),
    .phase_a_curr_rms(rms[3]), .phase_b_curr_rms(rms[4]),
    .phase_c_curr_rms(rms[5]), .half_full_pulse(half_full_pulse));

  always #50 pclk = ~pclk;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // note the expected answer, then read
  task automatic rd(input logic [7:0] a, input logic [31:0] v,
    input logic e, input int d, input int kl, input int kh);
    q.push_back('{v, e, d, kl, kh});
    apb(1'b0, a, 32'h0);
  endtask

  // energy is a whole number of steps, step count within a window
  task automatic note_chk(input taeacc_note_t n);
    logic [23:0] e;
    e = prdata[23:0];
    if (n.d == 0) begin
      `CHK(prdata, n.v)
      `CHK(pslverr, n.e)
    end else if (n.d > 0) begin
      `CHK((e % n.d == 0) && (e / n.d >= n.kl) && (e / n.d <= n.kh), 1'b1)
    end
  endtask

  // clear, integrate for ten sample periods, then read both views
  task automatic meas(input int d);
    rd(OFF_ENERGY_RC, 32'h0, 1'b0, -1, 0, 0);
    repeat (120) @(posedge pclk);
    rd(OFF_ENERGY, 32'h0, 1'b0, d, 8, 11);
    rd(OFF_ENERGY_RC, 32'h0, 1'b0, d, 8, 12);
    repeat (2) @(posedge pclk);
    rd(OFF_ENERGY, 32'h0, 1'b0, d, 0, 1);
  endtask

  // result watcher: event count and read data against oldest note
  always @(posedge pclk) begin
    if (half_full_pulse === 1'b1) begin
      pulses++;
    end
    if (psel && penable && pready && !pwrite) begin
      note_chk(q.pop_front());
    end
  end

  // hang guard
  initial begin
    repeat (90000) @(posedge pclk);
    miscompares++;
    wrap_up();
  end

  // main sequence
  initial begin
    int r;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_MODE, 32'h7, 1'b0, 0, 0, 0);
    rd(OFF_DIV, 32'h0, 1'b0, 0, 0, 0);
    rd(OFF_CTRL, 32'h0, 1'b0, 0, 0, 0);
    apb(1'b1, OFF_ENERGY, 32'hffffff);
    rd(OFF_ENERGY, 32'h0, 1'b0, 0, 0, 0);
    r = $unsigned($random(seed)) % 53;
    rd(8'h2c + 8'(4 * r), 32'h0, 1'b1, 0, 0, 0);
    for (int i = 0; i < 9; i++) begin
      for (int j = 0; j < 6; j++) begin
        req[j] <= (tbl[i][j+1] < 0) ? 24'($random(seed)) :
          24'(tbl[i][j+1]);
      end
      apb(1'b1, OFF_VAG[0], 32'(tbl[i][7]));
      apb(1'b1, OFF_APG[0], 32'(tbl[i][8]));
      apb(1'b1, OFF_DIV, 32'(tbl[i][9]));
      apb(1'b1, OFF_MODE, 32'(tbl[i][0]));
      rd(OFF_MODE, 32'(tbl[i][0]), 1'b0, 0, 0, 0);
      repeat (48) @(posedge pclk);
      meas(tbl[i][10]);
    end
    // long run through half full and past the positive wrap
    apb(1'b1, OFF_CTRL, 32'h1);
    rd(OFF_ENERGY_RC, 32'h0, 1'b0, -1, 0, 0);
    repeat (14400) @(posedge pclk);
    rd(OFF_ENERGY, 32'h0, 1'b0, 8192, 1195, 1201);
    `CHK(pulses, 1)
    rd(OFF_CTRL, 32'h3, 1'b0, 0, 0, 0);
    apb(1'b1, OFF_CTRL, 32'h2);
    rd(OFF_CTRL, 32'h1, 1'b0, 0, 0, 0);
    wrap_up();
  end
endmodule

`default_nettype wire
